// ==== design/sut_prescaler.v ====
// Two-way prescaler that turns the system clock into operation clock enable pulses.
`timescale 1ns/100ps
`default_nettype none
`include "sut_regs.vh"
module sut_prescaler (
    // Clock and reset.
    input  wire        clk,
    input  wire        reset_n,
    // Selection.
    input  wire [15:0] prescaleSelect,
    input  wire        clockPick,
    input  wire        timerIrq,
    // Operation clock enable.
    output reg         opClockEn
);
    reg  [10:0] divCount;
    reg  [10:0] divCountPrev;
    wire [3:0]  code;
    wire [10:0] toggled;
    wire        tick;
    assign code = clockPick ? prescaleSelect[7:4] : prescaleSelect[3:0];
    assign toggled = divCount & ~divCountPrev;
    // A rising bit k of the free counter recurs every 2^(k+1) cycles, so bit code-1 gives fclk/2^code.
    assign tick = (code == 4'h0) ? 1'b1 :
                  (code == `SUT_CODE_TIMER) ? timerIrq :
                  (code > `SUT_CODE_MAX) ? 1'b0 :
                  toggled[code - 4'h1];
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            divCount <= 11'h000;
            divCountPrev <= 11'h000;
            opClockEn <= 1'b0;
        end else begin
            divCount <= divCount + 11'h001;
            divCountPrev <= divCount;
            opClockEn <= tick;
        end
    end
endmodule
`default_nettype wire

// ==== design/sut_regs.vh ====
// Register offsets, field positions, reset values and prescaler codes of the transmit channel.
`ifndef SUT_REGS_VH
`define SUT_REGS_VH
`define SUT_ADDR_PRESCALE   8'h00
`define SUT_ADDR_MODE       8'h04
`define SUT_ADDR_CONFIG     8'h08
`define SUT_ADDR_DATA       8'h0C
`define SUT_ADDR_CONTROL    8'h10
`define SUT_ADDR_STATUS     8'h14
`define SUT_ADDR_IRQ_STAT   8'h18
`define SUT_ADDR_IRQ_MASK   8'h1C
`define SUT_MODE_CLKPICK    15
`define SUT_MODE_BUFEMPTY   0
`define SUT_CFG_DIR_LSB     0
`define SUT_CFG_INVERT      1
`define SUT_CFG_LEN_LO      2
`define SUT_CFG_PAR_LO      4
`define SUT_CFG_STOP2       6
`define SUT_DATA_DIV_HI     15
`define SUT_DATA_DIV_LO     9
`define SUT_CODE_TIMER      4'hF
`define SUT_CODE_MAX        4'hB
`define SUT_RESET_PRESCALE  16'h0000
`define SUT_RESET_MODE      16'h0000
`define SUT_RESET_CONFIG    8'h01
`define SUT_RESET_DATA      16'h0000
`define SUT_IRQ_TXEND       0
`define SUT_IRQ_BUFEMPTY    1
`define SUT_IRQ_ERROR       2
`endif

// ==== design/sut_uart_tx.v ====
// Transmit channel of the serial unit in UART mode with an AXI4-Lite register slave.
//
// Behaviour
// - Operation clock nibble chosen by mode register bit 15.
// - Prescaler codes zero to eleven divide system clock by two to the code.
// - Code all ones picks the timer interval interrupt; other unlisted codes forbidden.
// - Baud divider comes from data register bits 15 to 9.
// - Even channel only transmits; odd channel only receives.
// - Four UART instances map onto channel pairs of the two units.
// - Frame data length is 5, 7 or 8 bits.
// - Data goes out MSB first or LSB first.
// - Normal polarity idles high, inverted idles low, over the whole frame.
// - Optional parity (none, zero, even, odd) then one or two stop bits.
// - Interrupt at transfer end or buffer empty per mode bit; no error flags.
// - Receive-side errors reach a separate error interrupt of the pair; here they set irqStatus bit 2 and share irq with the transmit events.
//
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "sut_regs.vh"
module sut_uart_tx #(
    parameter UNIT_ID = 0,
    parameter TIMER_DIV_DEFAULT = 0
) (
    // Clock and reset.
    input  wire        clk,
    input  wire        reset_n,
    // AXI4-Lite write address and data.
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // AXI4-Lite write response.
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read.
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Timer interval interrupts and receive error event of the pair.
    input  wire        timerCh2IntervalIrq,
    input  wire        timerCh3IntervalIrq,
    input  wire        receiveErrorEvent,
    // Serial line and interrupt.
    output reg         serialTransmitLine,
    output reg         irq
);
    localparam ST_IDLE  = 4'b0001;
    localparam ST_START = 4'b0010;
    localparam ST_BITS  = 4'b0100;
    localparam ST_TAIL  = 4'b1000;

    reg  [15:0] prescaleSelect;
    reg  [15:0] channelMode;
    reg  [7:0]  frameConfig;
    reg  [15:0] channelData;
    reg         channelEnable;
    reg         bufferFull;
    reg  [2:0]  irqStatus;
    reg  [2:0]  irqMask;
    reg  [3:0]  state;
    reg  [7:0]  shiftData;
    reg  [3:0]  bitsLeft;
    reg  [7:0]  halfCount;
    reg         halfPhase;
    reg         lineLevel;
    reg         parityAcc;
    reg         awTaken;
    reg         wTaken;
    reg  [7:0]  awAddrHold;
    reg  [31:0] wDataHold;
    reg  [3:0]  wStrbHold;
    wire        opClockEn;
    wire        timerIrq;
    wire [6:0]  divider;
    wire [3:0]  dataLength;
    wire        bitEnd;
    wire        doWrite;
    wire [7:0]  wrAddr;
    wire [31:0] wrData;
    wire [3:0]  wrStrb;
    wire        loadFrame;
    wire        txEndEvent;
    wire        bufEmptyEvent;
    wire [2:0]  irqEvents;
    wire        parityBit;
    wire        hasParity;
    wire [3:0]  tailBits;

    //////////////////////////////////////////////////////////////////////
    // Register decoding and the AXI4-Lite slave.

    // Length codes: 0 and 3 give eight bits, 1 gives seven, 2 gives five.
    function [3:0] lenOf;
        input [1:0] code;
        begin
            lenOf = (code == 2'h1) ? 4'h7 : (code == 2'h2) ? 4'h5 : 4'h8;
        end
    endfunction

    function isMapped;
        input [7:0] addr;
        begin
            isMapped = (addr[1:0] == 2'h0) && (addr <= `SUT_ADDR_IRQ_MASK);
        end
    endfunction

    assign wrAddr = awTaken ? awAddrHold : s_axi_awaddr;
    assign wrData = wTaken ? wDataHold : s_axi_wdata;
    assign wrStrb = wTaken ? wStrbHold : s_axi_wstrb;
    assign doWrite = (awTaken || (s_axi_awvalid && s_axi_awready)) &&
                     (wTaken || (s_axi_wvalid && s_axi_wready)) && !s_axi_bvalid;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            awTaken <= 1'b0;
            wTaken <= 1'b0;
            awAddrHold <= 8'h00;
            wDataHold <= 32'h00000000;
            wStrbHold <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awAddrHold <= s_axi_awaddr;
                awTaken <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wDataHold <= s_axi_wdata;
                wStrbHold <= s_axi_wstrb;
                wTaken <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (doWrite) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= isMapped(wrAddr) ? 2'h0 : 2'h2;
                awTaken <= 1'b0;
                wTaken <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= isMapped(s_axi_araddr) ? 2'h0 : 2'h2;
                case (s_axi_araddr)
                    `SUT_ADDR_PRESCALE: s_axi_rdata <= {16'h0000, prescaleSelect};
                    `SUT_ADDR_MODE:     s_axi_rdata <= {16'h0000, channelMode};
                    `SUT_ADDR_CONFIG:   s_axi_rdata <= {24'h000000, frameConfig};
                    `SUT_ADDR_DATA:     s_axi_rdata <= {16'h0000, channelData};
                    `SUT_ADDR_CONTROL:  s_axi_rdata <= {31'h00000000, channelEnable};
                    `SUT_ADDR_STATUS:   s_axi_rdata <= {29'h00000000, lineLevel, state != ST_IDLE, bufferFull};
                    `SUT_ADDR_IRQ_STAT: s_axi_rdata <= {29'h00000000, irqStatus};
                    `SUT_ADDR_IRQ_MASK: s_axi_rdata <= {29'h00000000, irqMask};
                    default:            s_axi_rdata <= 32'h00000000;
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Software registers, transmit buffer and interrupt status.

    assign loadFrame = channelEnable && bufferFull && (state == ST_IDLE);
    assign txEndEvent = bitEnd && (state == ST_TAIL) && (bitsLeft == 4'h1);
    assign bufEmptyEvent = loadFrame;
    assign irqEvents = {receiveErrorEvent,
                        bufEmptyEvent && channelMode[`SUT_MODE_BUFEMPTY],
                        txEndEvent && !channelMode[`SUT_MODE_BUFEMPTY]};

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prescaleSelect <= `SUT_RESET_PRESCALE;
            channelMode <= `SUT_RESET_MODE;
            frameConfig <= `SUT_RESET_CONFIG;
            channelData <= `SUT_RESET_DATA;
            channelEnable <= 1'b0;
            bufferFull <= 1'b0;
            irqStatus <= 3'h0;
            irqMask <= 3'h0;
            irq <= 1'b0;
        end else begin
            if (loadFrame) begin
                bufferFull <= 1'b0;
            end
            if (doWrite && wrStrb[0]) begin
                case (wrAddr)
                    `SUT_ADDR_PRESCALE: prescaleSelect[7:0] <= wrData[7:0];
                    `SUT_ADDR_MODE:     channelMode[7:0] <= wrData[7:0];
                    `SUT_ADDR_CONFIG:   frameConfig <= wrData[7:0];
                    `SUT_ADDR_CONTROL:  channelEnable <= wrData[0];
                    `SUT_ADDR_IRQ_MASK: irqMask <= wrData[2:0];
                    `SUT_ADDR_DATA: begin
                        // A write while the buffer is full overwrites the waiting byte.
                        channelData[7:0] <= wrData[7:0];
                        bufferFull <= 1'b1;
                    end
                    default: begin
                    end
                endcase
            end
            if (doWrite && wrStrb[1]) begin
                case (wrAddr)
                    `SUT_ADDR_PRESCALE: prescaleSelect[15:8] <= wrData[15:8];
                    `SUT_ADDR_MODE:     channelMode[15:8] <= wrData[15:8];
                    `SUT_ADDR_DATA:     channelData[15:8] <= wrData[15:8];
                    default: begin
                    end
                endcase
            end
            // A set arriving in the clearing cycle survives.
            irqStatus <= (irqStatus & ~((doWrite && wrStrb[0] && wrAddr == `SUT_ADDR_IRQ_STAT) ?
                         wrData[2:0] : 3'h0)) | irqEvents;
            irq <= |(irqStatus & irqMask);
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Operation clock, bit timing and frame shifter.

    // Unit 0 follows timer channel 2 and unit 1 timer channel 3.
    assign timerIrq = (UNIT_ID == 0) ? timerCh2IntervalIrq : timerCh3IntervalIrq;

    sut_prescaler u_prescaler (
        .clk            (clk),
        .reset_n        (reset_n),
        .prescaleSelect (prescaleSelect),
        .clockPick      (channelMode[`SUT_MODE_CLKPICK]),
        .timerIrq       (timerIrq),
        .opClockEn      (opClockEn)
    );

    assign divider = channelData[`SUT_DATA_DIV_HI:`SUT_DATA_DIV_LO];
    assign bitEnd = opClockEn && halfPhase && (halfCount == 8'h00);
    assign dataLength = lenOf(frameConfig[`SUT_CFG_LEN_LO+1:`SUT_CFG_LEN_LO]);
    assign hasParity = frameConfig[`SUT_CFG_PAR_LO+1:`SUT_CFG_PAR_LO] != 2'h0;
    assign parityBit = (frameConfig[`SUT_CFG_PAR_LO+1:`SUT_CFG_PAR_LO] == 2'h1) ? 1'b0 :
                       (parityAcc ^ lineLevel ^ (frameConfig[`SUT_CFG_PAR_LO+1:`SUT_CFG_PAR_LO] == 2'h3));
    assign tailBits = {3'h0, hasParity} + (frameConfig[`SUT_CFG_STOP2] ? 4'h2 : 4'h1);

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_IDLE;
            shiftData <= 8'h00;
            bitsLeft <= 4'h0;
            halfCount <= 8'h00;
            halfPhase <= 1'b0;
            lineLevel <= 1'b1;
            parityAcc <= 1'b0;
            serialTransmitLine <= 1'b1;
        end else begin
            // Each half period lasts divider plus one operation clock cycles.
            if (opClockEn && state != ST_IDLE) begin
                if (halfCount == 8'h00) begin
                    halfCount <= {1'b0, divider};
                    halfPhase <= ~halfPhase;
                end else begin
                    halfCount <= halfCount - 8'h01;
                end
            end
            case (state)
                ST_IDLE: begin
                    lineLevel <= 1'b1;
                    if (loadFrame) begin
                        state <= ST_START;
                        lineLevel <= 1'b0;
                        halfCount <= {1'b0, divider};
                        halfPhase <= 1'b0;
                        parityAcc <= 1'b0;
                        shiftData <= frameConfig[`SUT_CFG_DIR_LSB] ? channelData[7:0] :
                                     (channelData[7:0] << (4'h8 - dataLength));
                    end
                end
                ST_START: begin
                    if (bitEnd) begin
                        state <= ST_BITS;
                        bitsLeft <= dataLength;
                        lineLevel <= frameConfig[`SUT_CFG_DIR_LSB] ? shiftData[0] : shiftData[7];
                    end
                end
                ST_BITS: begin
                    if (bitEnd) begin
                        parityAcc <= parityAcc ^ lineLevel;
                        shiftData <= frameConfig[`SUT_CFG_DIR_LSB] ? {1'b0, shiftData[7:1]} :
                                     {shiftData[6:0], 1'b0};
                        if (bitsLeft == 4'h1) begin
                            state <= ST_TAIL;
                            bitsLeft <= tailBits;
                            lineLevel <= hasParity ? parityBit : 1'b1;
                        end else begin
                            bitsLeft <= bitsLeft - 4'h1;
                            lineLevel <= frameConfig[`SUT_CFG_DIR_LSB] ? shiftData[1] : shiftData[6];
                        end
                    end
                end
                ST_TAIL: begin
                    if (bitEnd) begin
                        lineLevel <= 1'b1;
                        if (bitsLeft == 4'h1) begin
                            state <= ST_IDLE;
                        end else begin
                            bitsLeft <= bitsLeft - 4'h1;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
            serialTransmitLine <= lineLevel ^ frameConfig[`SUT_CFG_INVERT];
        end
    end
endmodule
`default_nettype wire

// ==== verification/sut_serial_receiver.sv ====
// Behavioural remote receiver that samples the serial transmit line.
`timescale 1ns/100ps
`default_nettype none
module sut_serial_receiver (
    // Clock and reset.
    input wire logic        clk,
    input wire logic        reset_n,
    // Line and frame format.
    input wire logic        line,
    input wire logic        invert,
    input wire logic        armed,
    input wire logic [15:0] bitCycles,
    input wire logic [3:0]  frameBits,
    // Captured frame.
    output var logic [11:0] rxBits,
    output var logic        rxStart,
    output var logic        frameDone
);
    initial begin
        rxBits = 12'hFFF;
        rxStart = 1'b1;
        frameDone = 1'b0;
        forever begin
            @(posedge clk);
            // Only an armed receiver hunts, since a polarity change looks like a start edge.
            if (reset_n && armed && (line ^ invert) == 1'b0) begin
                rxBits = 12'hFFF;
                repeat (bitCycles / 2) @(posedge clk);
                rxStart = line ^ invert;
                for (int i = 0; i < frameBits; i++) begin
                    repeat (bitCycles) @(posedge clk);
                    rxBits[i] = line ^ invert;
                end
                frameDone = 1'b1;
                @(posedge clk);
                frameDone = 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ==== verification/sut_uart_tx_asserts.sv ====
// Port-level assertions for the UART transmit channel.
`timescale 1ns/100ps
`default_nettype none
module sut_uart_tx_asserts (
    // Clock and reset.
    input wire logic        clk,
    input wire logic        reset_n,
    // Register bus.
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Line and interrupt.
    input wire logic        serialTransmitLine,
    input wire logic        irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    a_reset_idle: assert property ($rose(reset_n) |-> serialTransmitLine && !irq)
        else $error("Line or irq not idle after reset.");
    // Dividers of two and up, with any prescaler code, never give a bit shorter than six clocks.
    a_bit_width: assert property ($changed(serialTransmitLine) |=> $stable(serialTransmitLine) [*5])
        else $error("Line bit shorter than six clocks.");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("No write response after both halves.");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("No read data after address.");
    a_bvalid_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("Write taken while response pending.");
    a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("Write response not released.");
    a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("Read data not released.");
    a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h1C
        |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("Unmapped read not refused.");
    a_irq_cause: assert property ($fell(irq) |-> $past(s_axi_wvalid, 1) || $past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3))
        else $error("Interrupt dropped without a register write.");
endmodule
bind sut_uart_tx sut_uart_tx_asserts i_sut_uart_tx_asserts (.clk, .reset_n, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serialTransmitLine, .irq);
`default_nettype wire

// ==== verification/sut_uart_tx_tb_top.sv ====
// Self-checking bench for the UART transmit channel.
`timescale 1ns/100ps
`default_nettype none
`include "sut_regs.vh"
module sut_uart_tx_tb_top;
    logic        clk = 1'b0, reset_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, tick2 = 1'b0, tick3 = 1'b0, errEvent = 1'b0;
    logic        invert = 1'b0, armed = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, txLine, irq, rxStart, frameDone;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rdVal, seed = 32'h0000071A;
    logic [1:0]  bresp, rresp, resp, tickCnt = 2'h0;
    logic [15:0] bitCycles = 16'h0006;
    logic [11:0] rxBits;
    logic [3:0]  frameBits = 4'hA, code;
    logic [6:0]  cfg, div;
    int          failures = 0, totalChecks = 0, cycles = 0;
    sut_uart_tx i_sut_uart_tx (.clk(clk), .reset_n(reset_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .timerCh2IntervalIrq(tick2), .timerCh3IntervalIrq(tick3), .receiveErrorEvent(errEvent),
        .serialTransmitLine(txLine), .irq(irq));
    sut_serial_receiver i_sut_serial_receiver (.clk(clk), .reset_n(reset_n), .line(txLine), .invert(invert),
        .armed(armed), .bitCycles(bitCycles), .frameBits(frameBits), .rxBits(rxBits), .rxStart(rxStart),
        .frameDone(frameDone));
    ////////////////////////////////////////
    always #4 clk = ~clk;
    // Timer channel 2 pulses every third clock; channel 3 runs another pattern, so a wrong pick breaks the frame.
    always @(posedge clk) begin
        tickCnt <= (tickCnt == 2'h2) ? 2'h0 : tickCnt + 2'h1;
        tick2 <= tickCnt == 2'h2;
        tick3 <= tickCnt != 2'h0;
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            failures++;
            end_of_test();
        end
    end
    ////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", totalChecks, failures);
        if (failures == 0 && totalChecks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rdVal = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        check("read data", rdVal, e);
    endtask
    function automatic logic [31:0] nextRand(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic int lenOf(input logic [6:0] c);
        return (c[3:2] == 2'h1) ? 7 : (c[3:2] == 2'h2) ? 5 : 8;
    endfunction
    // Bits after the start bit in line order; unused places read as idle ones.
    function automatic logic [11:0] frameOf(input logic [6:0] c, input logic [7:0] b);
        logic [11:0] f;
        int          n;
        n = lenOf(c);
        f = 12'hFFF;
        for (int k = 0; k < n; k++) f[k] = c[0] ? b[k] : b[n - 1 - k];
        if (c[5:4] != 2'h0) f[n] = (c[5:4] == 2'h1) ? 1'b0 : (^(b & 8'((1 << n) - 1))) ^ (c[5:4] == 2'h3);
        return f;
    endfunction
    task automatic setup(input logic [6:0] c, input logic [3:0] k, input logic pick, input logic m0, input logic [6:0] d);
        // The clock source only changes while no frame is on the line.
        wr(`SUT_ADDR_PRESCALE, pick ? {24'h0, k, 4'hC} : {24'h0, 4'hC, k});
        wr(`SUT_ADDR_MODE, {16'h0, pick, 14'h0, m0});
        wr(`SUT_ADDR_CONFIG, {25'h0, c});
        // A polarity change moves the idle level; let it settle before the next edge.
        repeat (8) @(posedge clk);
        check("idle level", txLine, !c[1]);
        invert <= c[1];
        frameBits <= 4'(lenOf(c) + (c[5:4] != 2'h0) + 1 + c[6]);
        bitCycles <= 16'(2 * (int'(d) + 1) * ((k == 4'hF) ? 3 : (1 << k)));
        armed <= 1'b1;
    endtask
    task automatic getFrame(input logic [6:0] c, input logic [7:0] b);
        wait (frameDone);
        check("start bit", rxStart, 1'b0);
        check("frame bits", rxBits, frameOf(c, b));
        @(posedge clk);
        @(posedge clk);
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        rdChk(`SUT_ADDR_PRESCALE, {16'h0, `SUT_RESET_PRESCALE});
        rdChk(`SUT_ADDR_MODE, {16'h0, `SUT_RESET_MODE});
        rdChk(`SUT_ADDR_CONFIG, {24'h0, `SUT_RESET_CONFIG});
        rdChk(`SUT_ADDR_DATA, {16'h0, `SUT_RESET_DATA});
        rd(8'h20);
        check("unmapped read", resp, 32'h2);
        rd(8'h05);
        check("misaligned read", resp, 32'h2);
        wr(8'h24, 32'hFFFF);
        check("unmapped write", resp, 32'h2);
        wr(`SUT_ADDR_IRQ_MASK, 32'h7);
        wr(`SUT_ADDR_CONTROL, 32'h1);
        for (int i = 0; i < 16; i++) begin
            seed = nextRand(seed);
            cfg = {seed[0], i[3:2], i[1:0], seed[2:1]};
            code = (i % 5 == 4) ? 4'hF : {2'h0, seed[4:3]};
            div = 7'(2 + seed[6:5]);
            setup(cfg, code, seed[7], 1'b0, div);
            wr(`SUT_ADDR_DATA, {16'h0, div, 1'b0, seed[15:8]});
            getFrame(cfg, seed[15:8]);
            armed <= 1'b0;
            wait (irq);
            rdChk(`SUT_ADDR_IRQ_STAT, 32'h1);
            wr(`SUT_ADDR_IRQ_STAT, 32'h1);
            rdChk(`SUT_ADDR_IRQ_STAT, 32'h0);
            check("irq low", irq, 1'b0);
        end
        // Continuous mode: the second byte is queued while the first is on the line.
        setup(7'h01, 4'h0, 1'b0, 1'b1, 7'h2);
        wr(`SUT_ADDR_DATA, 32'h000004A5);
        wait (irq);
        rdChk(`SUT_ADDR_IRQ_STAT, 32'h2);
        wr(`SUT_ADDR_IRQ_STAT, 32'h2);
        wr(`SUT_ADDR_DATA, 32'h0000043C);
        getFrame(7'h01, 8'hA5);
        getFrame(7'h01, 8'h3C);
        armed <= 1'b0;
        wait (irq);
        rdChk(`SUT_ADDR_IRQ_STAT, 32'h2);
        wr(`SUT_ADDR_IRQ_STAT, 32'h2);
        errEvent <= 1'b1;
        @(posedge clk);
        errEvent <= 1'b0;
        rdChk(`SUT_ADDR_IRQ_STAT, 32'h4);
        check("irq high", irq, 1'b1);
        wr(`SUT_ADDR_IRQ_MASK, 32'h3);
        rdChk(`SUT_ADDR_IRQ_MASK, 32'h3);
        check("irq masked", irq, 1'b0);
        // A disabled channel keeps its byte waiting and the line idle.
        wr(`SUT_ADDR_CONTROL, 32'h0);
        wr(`SUT_ADDR_DATA, 32'h00000455);
        repeat (20) @(posedge clk);
        rdChk(`SUT_ADDR_STATUS, 32'h5);
        check("held line", txLine, 1'b1);
        end_of_test();
    end
endmodule
`default_nettype wire
